/* bench/flash_parameter_table_rom_tb_top.sv */
`timescale 1ns/1ns
module flash_parameter_table_rom_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  logic psel, penable, pwrite, pready, pslverr, soft_reset;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [31:0] seed = 32'h0000_002E;
  logic [31:0] tbl [64];
  logic e;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int pulses = 0;
  int ptr, m, p0;

  always #4 clk = ~clk;

  fptrom_top uut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .soft_reset(soft_reset));
  fptrom_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
    end
  endfunction

  function automatic logic [31:0] bt(input int a);
    return {24'h00_0000, tbl[(a >> 2) & 63][8 * (a & 3) +: 8]};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp_data(q, x);
    cmp_flag(e, xe);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic xe);
    host.xfer(1'b1, a, d, q, e);
    cmp_flag(e, xe);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (soft_reset === 1'b1)
      pulses++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  initial
  begin
    foreach (tbl[i])
      tbl[i] = 32'hFFFF_FFFF;
    tbl[15] = {8'hBB, 3'b100, 5'h00, 8'h3B, 3'b000, 5'h08};
    tbl[16] = 32'hFFFF_FFEE;
    tbl[17] = {8'hFF, 8'h00, 16'hFFFF};
    tbl[18] = {8'hFF, 8'h00, 16'hFFFF};
    tbl[19] = {8'h52, 8'h0F, 8'h20, 8'h0C};
    tbl[20] = {8'h81, 8'h08, 8'hD8, 8'h10};
    tbl[37] = {8'h64, 8'h77, 4'hF, 8'h99, 4'hE};
    tbl[38] = {16'hFFFF, 2'b11, 2'b00, 1'b1, 1'b0, 8'hFF, 2'b00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(fptrom_pkg::CTRL_OFF, 32'h0000_0001, 1'b0);
    rd(fptrom_pkg::PTR_OFF, 32'h0000_0000, 1'b0);
    rd(fptrom_pkg::STAT_OFF, 32'h0000_0000, 1'b0);
    $display("test reset values done");
    // whole window twice: contents never change between passes
    for (int k = 0; k < 128; k++)
      rd(fptrom_pkg::WIN_BASE + 12'(4 * (k & 63)), tbl[k & 63], 1'b0);
    $display("test table words done");
    wr(fptrom_pkg::PTR_OFF, 32'h0000_003C, 1'b0);
    ptr = 32'h3C;
    repeat (32)
    begin
      rd(fptrom_pkg::DATA_OFF, bt(ptr), 1'b0);
      ptr++;
    end
    rd(fptrom_pkg::STAT_OFF, 32'(ptr), 1'b0);
    $display("test serial bytes done");
    for (int len = 0; len < 4; len++)
    begin
      seed = xs(seed);
      ptr = seed & 32'hFF;
      m = (8 << len) - 1;
      wr(fptrom_pkg::CTRL_OFF, 32'(3 + 4 * len), 1'b0);
      wr(fptrom_pkg::PTR_OFF, 32'(ptr), 1'b0);
      repeat (m + 3)
      begin
        rd(fptrom_pkg::DATA_OFF, bt(ptr), 1'b0);
        ptr = (ptr & ~m) | ((ptr + 1) & m);
      end
    end
    // autoinc off: the pointer must stay put
    wr(fptrom_pkg::CTRL_OFF, 32'h0000_0000, 1'b0);
    repeat (3)
      rd(fptrom_pkg::DATA_OFF, bt(ptr), 1'b0);
    // clock enable low while the bus is idle: nothing may move
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    rd(fptrom_pkg::STAT_OFF, 32'(ptr), 1'b0);
    $display("test wrap and hold done");
    wr(fptrom_pkg::WIN_BASE + 12'h040, 32'h0000_0000, 1'b1);
    wr(12'h200, 32'h0000_0000, 1'b1);
    rd(12'h020, 32'h0000_0000, 1'b1);
    rd(fptrom_pkg::WIN_BASE + 12'h001, 32'h0000_0000, 1'b1);
    rd(fptrom_pkg::WIN_BASE + 12'h040, tbl[16], 1'b0);
    $display("test refusals done");
    wr(fptrom_pkg::PTR_OFF, 32'h0000_0005, 1'b0);
    // a write with its low strobe off is accepted and does nothing
    pstrb <= 4'h0;
    wr(fptrom_pkg::PTR_OFF, 32'h0000_0077, 1'b0);
    pstrb <= 4'hF;
    p0 = pulses;
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0099, 1'b0);
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0066, 1'b0);
    rd(fptrom_pkg::STAT_OFF, 32'h0000_0105, 1'b0);
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0020, 1'b0);
    rd(fptrom_pkg::STAT_OFF, 32'h0000_0005, 1'b0);
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0099, 1'b0);
    repeat (3) @(posedge clk);
    cmp_data(32'(pulses), 32'(p0));
    // reset enable sent directly before the reset command
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0066, 1'b0);
    wr(fptrom_pkg::CMD_OFF, 32'h0000_0099, 1'b0);
    repeat (3) @(posedge clk);
    cmp_data(32'(pulses), 32'(p0 + 1));
    rd(fptrom_pkg::CTRL_OFF, 32'h0000_0001, 1'b0);
    rd(fptrom_pkg::PTR_OFF, 32'h0000_0000, 1'b0);
    $display("test soft reset done");
    tally_and_finish();
  end
endmodule

/* bench/fptrom_host.sv */
`timescale 1ns/1ns
module fptrom_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // one word per transfer, request held until pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no limit here: a slave that never answers is caught by the bench timeout
      do
        @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

/* design/fptrom_pkg.sv */
package fptrom_pkg;
  // register offsets on the bus, byte addresses
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] PTR_OFF = 12'h004;
  localparam logic [11:0] DATA_OFF = 12'h008;
  localparam logic [11:0] STAT_OFF = 12'h00C;
  localparam logic [11:0] CMD_OFF = 12'h010;
  // table window: byte address of the table plus this base
  localparam logic [11:0] WIN_BASE = 12'h100;

  // control register fields
  localparam int unsigned CTRL_AUTOINC = 0;
  localparam int unsigned CTRL_WRAP_EN = 1;
  localparam int unsigned CTRL_LEN_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int unsigned STAT_ARMED = 8;

  // word indices of the table (byte address / 4)
  localparam logic [5:0] IDX_DUAL = 6'h0F;
  localparam logic [5:0] IDX_FLAGS = 6'h10;
  localparam logic [5:0] IDX_ALL_DUAL = 6'h11;
  localparam logic [5:0] IDX_ALL_QUAD = 6'h12;
  localparam logic [5:0] IDX_ERASE12 = 6'h13;
  localparam logic [5:0] IDX_ERASE34 = 6'h14;
  localparam logic [5:0] IDX_FEAT = 6'h25;
  localparam logic [5:0] IDX_LOCK = 6'h26;

  // fast read fields
  localparam logic [4:0] DUAL_OUT_WAIT = 5'h08;
  localparam logic [2:0] DUAL_OUT_MODE = 3'h0;
  localparam logic [7:0] DUAL_OUT_OP = 8'h3B;
  localparam logic [4:0] DUAL_IO_WAIT = 5'h00;
  localparam logic [2:0] DUAL_IO_MODE = 3'h4;
  localparam logic [7:0] DUAL_IO_OP = 8'hBB;
  localparam logic [7:0] UNSUP_OP = 8'hFF;
  localparam logic [7:0] NONE_FIELDS = 8'h00;

  // erase types: size code is log2 of bytes, zero means absent
  localparam logic [7:0] ERASE1_SIZE = 8'h0C;
  localparam logic [7:0] ERASE1_OP = 8'h20;
  localparam logic [7:0] ERASE2_SIZE = 8'h0F;
  localparam logic [7:0] ERASE2_OP = 8'h52;
  localparam logic [7:0] ERASE3_SIZE = 8'h10;
  localparam logic [7:0] ERASE3_OP = 8'hD8;
  localparam logic [7:0] ERASE4_SIZE = 8'h08;
  localparam logic [7:0] ERASE4_OP = 8'h81;

  // commands and feature codes
  localparam logic [7:0] RST_EN_OP = 8'h66;
  localparam logic [7:0] RST_OP = 8'h99;
  localparam logic [7:0] WRAP_OP = 8'h77;
  localparam logic [7:0] WRAP_LEN_CODE = 8'h64;
  localparam logic [7:0] LOCK_OP = 8'hFF;

  localparam logic [31:0] WORD_UNUSED = 32'hFFFF_FFFF;
  localparam logic [31:0] WORD_DUAL = {DUAL_IO_OP, DUAL_IO_MODE, DUAL_IO_WAIT,
                                       DUAL_OUT_OP, DUAL_OUT_MODE, DUAL_OUT_WAIT};
  // unused bits one, all-quad bit 4 and all-dual bit 0 zero
  localparam logic [31:0] WORD_FLAGS = {24'hFF_FFFF, 3'h7, 1'b0, 3'h7, 1'b0};
  localparam logic [31:0] WORD_NO_READ = {UNSUP_OP, NONE_FIELDS, 16'hFFFF};
  localparam logic [31:0] WORD_ERASE12 = {ERASE2_OP, ERASE2_SIZE, ERASE1_OP, ERASE1_SIZE};
  localparam logic [31:0] WORD_ERASE34 = {ERASE4_OP, ERASE4_SIZE, ERASE3_OP, ERASE3_SIZE};
  // wrap, unused, erase susp, program susp, reset op, sw rst, dpd, hold, hw rst
  localparam logic [31:0] WORD_FEAT = {WRAP_LEN_CODE, WRAP_OP, 4'hF, RST_OP,
                                       4'hE};
  // unused, perm lock, read lock, otp, volatile default, lock op, nonvol, lock
  localparam logic [31:0] WORD_LOCK = {16'hFFFF, 2'h3, 3'h1, 1'b0, LOCK_OP,
                                       2'h0};
endpackage

/* design/fptrom_rst_seq.sv */
`timescale 1ns/1ns
module fptrom_rst_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  output logic armed,
  output logic soft_rst
);
  logic armed_r;
  logic armed_nxt;
  logic soft_r;
  logic soft_nxt;

  always_comb
  begin
    armed_nxt = armed_r;
    soft_nxt = 1'b0;
    if (cmd_valid)
    begin
      armed_nxt = (cmd_op == fptrom_pkg::RST_EN_OP);
      soft_nxt = armed_r && (cmd_op == fptrom_pkg::RST_OP);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      armed_r <= 1'b0;
      soft_r <= 1'b0;
    end
    else if (ce)
    begin
      armed_r <= armed_nxt;
      soft_r <= soft_nxt;
    end
  end

  assign armed = armed_r;
  assign soft_rst = soft_r;

  pair_fires_a: assert property (@(posedge clk) disable iff (rst)
    ce && cmd_valid && armed_r && cmd_op == fptrom_pkg::RST_OP |=> soft_r)
    else $error("reset pair did not fire");
  lone_reset_a: assert property (@(posedge clk) disable iff (rst)
    ce && cmd_valid && !(armed_r && cmd_op == fptrom_pkg::RST_OP) |=> !soft_r)
    else $error("reset fired without enable");
  soft_reset_c: cover property (@(posedge clk) disable iff (rst) ce && soft_r);
endmodule

/* design/fptrom_table.sv */
`timescale 1ns/1ns
module fptrom_table (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rd_en,
  input wire logic [5:0] rd_idx,
  output logic [31:0] rd_word
);
  logic [31:0] word_r;
  logic [31:0] word_nxt;

  always_comb
  begin
    word_nxt = word_r;
    if (rd_en)
    begin
      case (rd_idx)
        fptrom_pkg::IDX_DUAL: word_nxt = fptrom_pkg::WORD_DUAL;
        fptrom_pkg::IDX_FLAGS: word_nxt = fptrom_pkg::WORD_FLAGS;
        fptrom_pkg::IDX_ALL_DUAL: word_nxt = fptrom_pkg::WORD_NO_READ;
        fptrom_pkg::IDX_ALL_QUAD: word_nxt = fptrom_pkg::WORD_NO_READ;
        fptrom_pkg::IDX_ERASE12: word_nxt = fptrom_pkg::WORD_ERASE12;
        fptrom_pkg::IDX_ERASE34: word_nxt = fptrom_pkg::WORD_ERASE34;
        fptrom_pkg::IDX_FEAT: word_nxt = fptrom_pkg::WORD_FEAT;
        fptrom_pkg::IDX_LOCK: word_nxt = fptrom_pkg::WORD_LOCK;
        default: word_nxt = fptrom_pkg::WORD_UNUSED;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      word_r <= fptrom_pkg::WORD_UNUSED;
    else if (ce)
      word_r <= word_nxt;
  end

  assign rd_word = word_r;

  dual_word_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_DUAL |=> rd_word == 32'hBB80_3B08)
    else $error("dual read word wrong");
  flag_word_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_FLAGS |=> rd_word == 32'hFFFF_FFEE)
    else $error("full width flag word wrong");
  no_read_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (rd_idx == fptrom_pkg::IDX_ALL_DUAL || rd_idx == fptrom_pkg::IDX_ALL_QUAD)
    |=> rd_word == 32'hFF00_FFFF)
    else $error("unsupported read word wrong");
  erase_lo_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_ERASE12 |=> rd_word == 32'h520F_200C)
    else $error("erase types 1 2 wrong");
  erase_hi_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_ERASE34 |=> rd_word == 32'h8108_D810)
    else $error("erase types 3 4 wrong");
  feat_word_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_FEAT |=> rd_word == 32'h6477_F99E)
    else $error("feature word wrong");
  lock_word_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && rd_idx == fptrom_pkg::IDX_LOCK |=> rd_word == 32'hFFFF_CBFC)
    else $error("lock word wrong");
  unused_ones_a: assert property (@(posedge clk) disable iff (rst)
    ce && rd_en && (rd_idx < fptrom_pkg::IDX_DUAL || rd_idx > fptrom_pkg::IDX_LOCK)
    |=> rd_word == fptrom_pkg::WORD_UNUSED)
    else $error("unused word not all ones");
endmodule

/* design/fptrom_top.sv */
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
// Behaviour
// - dual-output fast read shows 8 wait clocks, no mode bits, opcode 3BH.
// - dual-io fast read shows 0 wait clocks, mode field 100b, opcode BBH.
// - all-dual fast read reads unsupported, zero fields, opcode FFH.
// - all-quad fast read reads unsupported, zero fields, opcode FFH.
// - erase sizes are log2 bytes, zero absent; type 1 is 0CH with 20H.
// - erase type 2 is size 0FH (32 KB) with opcode 52H.
// - erase type 3 is size 10H (64 KB) with opcode D8H.
// - erase type 4 is size 08H (256 bytes) with opcode 81H.
// - software reset acts only on 66H followed directly by 99H.
// - wrap read uses opcode 77H, length code 64H gives 8 to 64 bytes.
// - hold pin reads supported, hardware reset pin unsupported.
// - deep power-down and software reset read supported.
// - program and erase suspend/resume read supported.
// - block locking unsupported, lock opcode FFH, volatile default zero.
// - secured OTP supported, read lock and permanent lock unsupported.
// - every unused bit of the table reads as one.
module fptrom_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic soft_reset
);
  logic setup;
  logic access;
  logic done;
  logic win_hit;
  logic reg_hit;
  logic bad_req;
  logic [5:0] rom_idx;
  logic [31:0] rom_q;
  logic [7:0] data_byte;
  logic [7:0] wrap_mask;
  logic [7:0] ptr_step;
  logic [31:0] rd_mux;
  logic cmd_valid;
  logic armed;
  logic soft_rst;

  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic [1:0] bytesel_r;
  logic [1:0] bytesel_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  // request decode
  always_comb
  begin
    setup = psel && !penable;
    access = psel && penable;
    done = access && pready_r;
    win_hit = (paddr[11:8] == fptrom_pkg::WIN_BASE[11:8]);
    reg_hit = (paddr == fptrom_pkg::CTRL_OFF) || (paddr == fptrom_pkg::PTR_OFF) ||
              (paddr == fptrom_pkg::DATA_OFF) || (paddr == fptrom_pkg::STAT_OFF) ||
              (paddr == fptrom_pkg::CMD_OFF);
    // the table is read only; a write into it is refused
    bad_req = !(reg_hit || (win_hit && paddr[1:0] == 2'h0)) || (win_hit && pwrite);
    // a window access reads the addressed word, anything else the pointer word
    rom_idx = win_hit ? paddr[7:2] : ptr_r[7:2];
  end

  // table lookup is registered and taken at the setup edge, so the word is ready in the first access cycle
  fptrom_table u_table (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rd_en(setup),
    .rd_idx(rom_idx),
    .rd_word(rom_q)
  );

  fptrom_rst_seq u_rst_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cmd_valid(cmd_valid),
    .cmd_op(pwdata[7:0]),
    .armed(armed),
    .soft_rst(soft_rst)
  );

  // pointer stepping and byte extraction
  always_comb
  begin
    data_byte = rom_q[{bytesel_r, 3'h0} +: 8];
    wrap_mask = 8'((9'h008 << ctrl_r[fptrom_pkg::CTRL_LEN_LSB +: 2]) - 9'h001);
    if (ctrl_r[fptrom_pkg::CTRL_WRAP_EN])
      ptr_step = (ptr_r & ~wrap_mask) | (8'(ptr_r + 8'h01) & wrap_mask);
    else
      ptr_step = 8'(ptr_r + 8'h01);
  end

  // read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (win_hit)
      rd_mux = rom_q;
    else
    begin
      case (paddr)
        fptrom_pkg::CTRL_OFF: rd_mux = {28'h000_0000, ctrl_r};
        fptrom_pkg::PTR_OFF: rd_mux = {24'h00_0000, ptr_r};
        fptrom_pkg::DATA_OFF: rd_mux = {24'h00_0000, data_byte};
        fptrom_pkg::STAT_OFF: rd_mux = {23'h00_0000, armed, ptr_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // bus answer: one wait cycle, then pready for exactly one cycle
  always_comb
  begin
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    bytesel_nxt = bytesel_r;
    if (setup)
      bytesel_nxt = ptr_r[1:0];
    if (access && !pready_r)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = bad_req;
      if (!pwrite)
        prdata_nxt = bad_req ? 32'h0000_0000 : rd_mux;
    end
  end

  // register state and side effects, taken at the completing edge; the soft reset clear lands one edge later
  always_comb
  begin
    ptr_nxt = ptr_r;
    ctrl_nxt = ctrl_r;
    cmd_valid = 1'b0;
    if (soft_rst)
    begin
      ptr_nxt = fptrom_pkg::PTR_RESET;
      ctrl_nxt = fptrom_pkg::CTRL_RESET;
    end
    else if (done && !pslverr_r)
    begin
      if (pwrite)
      begin
        if (pstrb[0])
        begin
          case (paddr)
            fptrom_pkg::CTRL_OFF: ctrl_nxt = pwdata[3:0];
            fptrom_pkg::PTR_OFF: ptr_nxt = pwdata[7:0];
            fptrom_pkg::CMD_OFF: cmd_valid = 1'b1;
            default: ctrl_nxt = ctrl_r;
          endcase
        end
      end
      else if (paddr == fptrom_pkg::DATA_OFF && ctrl_r[fptrom_pkg::CTRL_AUTOINC])
      begin
        ptr_nxt = ptr_step;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_r <= fptrom_pkg::PTR_RESET;
      ctrl_r <= fptrom_pkg::CTRL_RESET;
      bytesel_r <= 2'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ptr_r <= ptr_nxt;
      ctrl_r <= ctrl_nxt;
      bytesel_r <= bytesel_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign soft_reset = soft_rst;

  pready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ce && done |=> !pready_r)
    else $error("pready held past completion");
  wait_one_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r |=> pready_r)
    else $error("answer not after one wait cycle");
  ptr_step_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && !pslverr_r && paddr == fptrom_pkg::DATA_OFF &&
    ctrl_r[fptrom_pkg::CTRL_AUTOINC] && !ctrl_r[fptrom_pkg::CTRL_WRAP_EN]
    |=> ptr_r == 8'($past(ptr_r) + 8'h01))
    else $error("pointer did not advance by one");
  wrap_keep_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && paddr == fptrom_pkg::DATA_OFF &&
    ctrl_r[fptrom_pkg::CTRL_AUTOINC] && ctrl_r[fptrom_pkg::CTRL_WRAP_EN]
    |=> (ptr_r & ~$past(wrap_mask)) == ($past(ptr_r) & ~$past(wrap_mask)))
    else $error("wrap read left its window");
  soft_clear_a: assert property (@(posedge clk) disable iff (rst)
    ce && soft_rst |=> ptr_r == fptrom_pkg::PTR_RESET && ctrl_r == fptrom_pkg::CTRL_RESET)
    else $error("soft reset did not clear state");
  win_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r && win_hit && pwrite |=> pready_r && pslverr_r)
    else $error("table write not refused");
  data_byte_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r && !pwrite && paddr == fptrom_pkg::DATA_OFF
    |=> prdata_r == {24'h00_0000, $past(data_byte)})
    else $error("data byte read wrong");

  // refusals: flagged with ready, no data leaks out
  refuse_zero_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r && !pwrite && bad_req
    |=> pslverr_r && prdata_r == 32'h0000_0000)
    else $error("refused read did not return zero");
  err_ready_a: assert property (@(posedge clk) disable iff (rst)
    pslverr_r |-> pready_r)
    else $error("error flag without ready");
  unmapped_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r && !reg_hit && !win_hit |=> pslverr_r)
    else $error("unmapped address not refused");
  unaligned_a: assert property (@(posedge clk) disable iff (rst)
    ce && access && !pready_r && win_hit && paddr[1:0] != 2'h0 |=> pslverr_r)
    else $error("unaligned window address not refused");
  idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ce && !psel |=> !pready_r)
    else $error("ready without a request");

  // register writes land only at the completing edge
  ptr_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && pwrite && !pslverr_r && pstrb[0] && paddr == fptrom_pkg::PTR_OFF &&
    !soft_rst |=> ptr_r == 8'($past(pwdata)))
    else $error("pointer write lost");
  ctrl_write_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && pwrite && !pslverr_r && pstrb[0] && paddr == fptrom_pkg::CTRL_OFF &&
    !soft_rst |=> ctrl_r == 4'($past(pwdata)))
    else $error("control write lost");
  strobe_off_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && pwrite && !pstrb[0] && !soft_rst
    |=> ptr_r == $past(ptr_r) && ctrl_r == $past(ctrl_r) && armed == $past(armed))
    else $error("write without strobe had an effect");

  // no read moves the pointer except a completed data read with autoinc on
  read_still_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && paddr != fptrom_pkg::DATA_OFF && !soft_rst
    |=> ptr_r == $past(ptr_r))
    else $error("pointer moved on another read");
  hold_ptr_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && !ctrl_r[fptrom_pkg::CTRL_AUTOINC] && !soft_rst
    |=> ptr_r == $past(ptr_r))
    else $error("pointer moved with autoinc off");
  freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce
    |=> $stable(ptr_r) && $stable(ctrl_r) && $stable(pready_r) && $stable(prdata_r))
    else $error("state changed while clock enable low");

  // reset enable arms; the pair is consumed by the pulse
  arm_on_enable_a: assert property (@(posedge clk) disable iff (rst)
    ce && done && pwrite && !pslverr_r && pstrb[0] && paddr == fptrom_pkg::CMD_OFF &&
    pwdata[7:0] == fptrom_pkg::RST_EN_OP && !soft_rst |=> armed)
    else $error("reset enable did not arm");
  pair_used_a: assert property (@(posedge clk) disable iff (rst)
    ce && soft_rst |-> !armed)
    else $error("still armed after reset");
  soft_once_a: assert property (@(posedge clk) disable iff (rst)
    ce && soft_rst |=> !soft_rst)
    else $error("soft reset longer than one cycle");

  win_read_c: cover property (@(posedge clk) disable iff (rst)
    ce && done && win_hit && !pwrite);
  serial_read_c: cover property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && paddr == fptrom_pkg::DATA_OFF);
  wrap_turn_c: cover property (@(posedge clk) disable iff (rst)
    ce && done && !pwrite && ctrl_r[fptrom_pkg::CTRL_WRAP_EN] &&
    paddr == fptrom_pkg::DATA_OFF && (ptr_r & wrap_mask) == wrap_mask);
  refuse_c: cover property (@(posedge clk) disable iff (rst)
    ce && done && pslverr_r);
endmodule
